// File: common/ptcc_pkg.sv
// ptcc_pkg: register map, field positions, reset values and encodings of the timer channel
// assumes a classic Wishbone slave with 32-bit data; register index times four is the byte address
package ptcc_pkg;
   // register indices; the byte address is four times the index
   localparam logic [15:0] IDX_CTL = 16'h5420;
   localparam logic [15:0] IDX_CNT = 16'h5422;
   localparam logic [15:0] IDX_CCC = 16'h5424;
   localparam logic [15:0] IDX_A_DATA = 16'h5426;
   localparam logic [15:0] IDX_B_DATA = 16'h5428;
   localparam logic [15:0] IDX_MSK = 16'h542a;
   localparam logic [15:0] IDX_FLG = 16'h542c;
   // counter control fields
   localparam int CTL_RUN = 0;
   localparam int CTL_RESET = 1;
   localparam int CTL_ONE_SHOT = 2;
   localparam int CTL_CBUF = 3;
   // capture/compare control fields
   localparam int CC_A_MODE = 0;
   localparam int CC_A_INV = 1;
   localparam int CC_A_OMODE = 4;
   localparam int CC_A_EDGE = 6;
   localparam int CC_B_MODE = 8;
   localparam int CC_B_INV = 9;
   localparam int CC_B_OMODE = 12;
   localparam int CC_B_EDGE = 14;
   // flag and mask fields
   localparam int FLG_MATCH_A = 0;
   localparam int FLG_MATCH_B = 1;
   localparam int FLG_CAP_A = 2;
   localparam int FLG_CAP_B = 3;
   localparam int FLG_OVW_A = 4;
   localparam int FLG_OVW_B = 5;
   localparam int FLG_W = 6;
   // values after reset, and the top count at which the counter wraps
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [1:0] RST_FIELD2 = 2'h0;
   localparam logic [5:0] RST_FLAGS = 6'h00;
   localparam logic [15:0] CNT_TOP = 16'hffff;
   // capture edge encodings and output mode encodings
   localparam logic [1:0] EDGE_NONE = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   typedef enum logic [1:0] {OM_OFF, OM_SET_CLR, OM_TOG_A, OM_TOG_B} ptcc_omode_t;
endpackage

// File: hdl/ptcc_edge_unit.sv
// ptcc_edge_unit: capture trigger detector for one unit
// assumes the capture pin is already synchronous to CLK
`timescale 1ns/1ps
module ptcc_edge_unit
   import ptcc_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [1:0] edge_sel,
   input wire logic sig,
   output logic pulse
);
   logic prev_r;

   always_ff @(posedge clk)
   begin
      if (srst)
         prev_r <= 1'b0;
      else
         prev_r <= sig;
   end

   // bit 0 enables the rising edge, bit 1 the falling edge
   assign pulse = (edge_sel[0] & sig & ~prev_r) | (edge_sel[1] & ~sig & prev_r);

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   chk_edge_none: assert property (edge_sel == EDGE_NONE |-> !pulse)
      else $error("capture trigger fired with edge select off");
   chk_edge_rise: assert property (edge_sel == EDGE_RISE && !$past(srst) |-> pulse == $rose(sig))
      else $error("rising edge select does not follow the rising edge");
   chk_edge_fall: assert property (edge_sel == EDGE_FALL && !$past(srst) |-> pulse == $fell(sig))
      else $error("falling edge select does not follow the falling edge");
   chk_edge_both: assert property (edge_sel == EDGE_BOTH && !$past(srst) |-> pulse == (sig != $past(sig)))
      else $error("both edge select misses an edge");
endmodule

// File: hdl/ptcc_output_unit.sv
// ptcc_output_unit: one timer output driven by the compare A and B matches
// assumes the match inputs are one-cycle pulses in the CLK domain
`timescale 1ns/1ps
module ptcc_output_unit
   import ptcc_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [1:0] mode,
   input wire logic inv,
   input wire logic match_a,
   input wire logic match_b,
   output logic out
);
   ptcc_omode_t omode;
   logic state_r;
   logic state_nxt;
   logic out_r;

   assign omode = ptcc_omode_t'(mode);

   always_comb
   begin
      state_nxt = state_r;
      case (omode)
         OM_OFF: state_nxt = 1'b0;
         OM_SET_CLR: if (match_a) state_nxt = 1'b1; else if (match_b) state_nxt = 1'b0;
         OM_TOG_A: if (match_a) state_nxt = ~state_r;
         OM_TOG_B: if (match_b) state_nxt = ~state_r;
         default: state_nxt = 1'b0;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state_r <= 1'b0;
         out_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         out_r <= state_nxt ^ inv;
      end
   end

   assign out = out_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   chk_out_toggle: assert property (omode == OM_TOG_A && match_a && $stable(inv) |=> out != $past(out))
      else $error("output did not toggle on compare A");
   chk_out_off: assert property (omode == OM_OFF |=> out == $past(inv))
      else $error("output in off mode is not at its idle level");
endmodule

// File: hdl/ptcc_top.sv
// ptcc_top: one 16-bit timer channel with two compare/capture units and a Wishbone register slave
// assumes COUNT_TICK is a one-cycle enable from an outside count clock divider
// Behaviour
// - the one-shot bit stops the counter after one period, when clear the counter repeats
// - the run bit starts counting when written 1 and halts it when written 0, and is 0 after reset
// - the present 16-bit count is readable, read only, and is zero after reset
// - the unit B trigger field selects both edges, falling, rising or no capture for 3, 2, 1, 0
// - the unit A trigger field uses the same edge encoding as unit B
// - the unit B mode bit makes its data register a capture register when set, a compare value when clear
// - the unit A mode bit makes its data register a capture register when set, a compare value when clear
// - the unit A data register is 16-bit read/write, holds compare value or captured count, resets to zero
// - the unit B data register is 16-bit read/write, holds compare value or captured count, resets to zero
// - match, capture and overwrite events each set their own flag, which a write of 1 clears
`timescale 1ns/1ps
module ptcc_top
   import ptcc_pkg::*;
(
   input wire logic CLK,
   input wire logic SRST,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [17:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   input wire logic COUNT_TICK,
   input wire logic CAP_A,
   input wire logic CAP_B,
   output logic TIMER_OUTPUT_A,
   output logic TIMER_OUTPUT_B,
   output logic IRQ
);
   function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
      hit = (a == b);
   endfunction

   function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [15:0] nw, input logic [1:0] sel);
      wmerge = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
   endfunction

   logic ack_r;
   logic [15:0] dat_r;
   logic run_r, run_nxt;
   logic one_shot_r, cbuf_r;
   logic [15:0] count_r, count_nxt;
   logic [1:0] a_edge_r, b_edge_r, a_omode_r, b_omode_r;
   logic a_inv_r, b_inv_r, a_mode_r, b_mode_r;
   logic [15:0] a_val_r, a_val_nxt, b_val_r, b_val_nxt;
   logic [15:0] a_act_r, b_act_r;
   logic [5:0] flag_r, flag_nxt, mask_r;

   // bus decode
   wire acc = WB_CYC_I & WB_STB_I & ~ack_r;
   wire wr = acc & WB_WE_I;
   wire rd = acc & ~WB_WE_I;
   wire [15:0] widx = WB_ADR_I[17:2];
   wire [15:0] wd = WB_DAT_I[15:0];
   wire [1:0] lanes = WB_SEL_I[1:0];
   wire hit_ctl = hit(widx, IDX_CTL);
   wire hit_cnt = hit(widx, IDX_CNT);
   wire hit_ccc = hit(widx, IDX_CCC);
   wire hit_a_dat = hit(widx, IDX_A_DATA);
   wire hit_b_dat = hit(widx, IDX_B_DATA);
   wire hit_msk = hit(widx, IDX_MSK);
   wire hit_flg = hit(widx, IDX_FLG);
   wire wr_ctl = wr & hit_ctl & lanes[0];
   wire wr_ccc_lo = wr & hit_ccc & lanes[0];
   wire wr_ccc_hi = wr & hit_ccc & lanes[1];
   wire ctl_reset_wr = wr_ctl & wd[CTL_RESET];

   // counting and comparing
   wire tick = COUNT_TICK & run_r;
   // with unit B capturing there is no period register, so the counter wraps at the top
   wire period_end = tick & (b_mode_r ? hit(count_r, CNT_TOP) : hit(count_r, b_act_r));
   wire match_a = tick & ~a_mode_r & hit(count_r, a_act_r);
   wire match_b = tick & ~b_mode_r & hit(count_r, b_act_r);

   // capturing
   wire edge_a, edge_b;
   wire cap_a = a_mode_r & edge_a;
   wire cap_b = b_mode_r & edge_b;
   wire ovw_a = cap_a & flag_r[FLG_CAP_A];
   wire ovw_b = cap_b & flag_r[FLG_CAP_B];
   wire [5:0] flag_set = {ovw_b, ovw_a, cap_b, cap_a, match_b, match_a};
   wire [5:0] flag_w1c = (wr & hit_flg & lanes[0]) ? wd[FLG_W-1:0] : RST_FLAGS;
   // a read also clears the flags so the interrupt can be served by one read
   wire [5:0] flag_rdc = (rd & hit_flg) ? ~RST_FLAGS : RST_FLAGS;

   wire [15:0] ccc_word = {b_edge_r, b_omode_r, 2'b00, b_inv_r, b_mode_r,
                           a_edge_r, a_omode_r, 2'b00, a_inv_r, a_mode_r};
   wire [15:0] ctl_word = {12'h000, cbuf_r, one_shot_r, 1'b0, run_r};
   wire [15:0] rd_word = hit_ctl ? ctl_word :
                         hit_cnt ? count_r :
                         hit_ccc ? ccc_word :
                         hit_a_dat ? a_val_r :
                         hit_b_dat ? b_val_r :
                         hit_msk ? {10'h000, mask_r} :
                         hit_flg ? {10'h000, flag_r} : RST_WORD;

   always_comb
   begin
      count_nxt = count_r;
      if (ctl_reset_wr)
         count_nxt = RST_WORD;
      else if (period_end)
         count_nxt = RST_WORD;
      else if (tick)
         count_nxt = count_r + 16'h0001;
   end

   always_comb
   begin
      run_nxt = run_r;
      if (wr_ctl)
         run_nxt = wd[CTL_RUN];
      else if (period_end & one_shot_r)
         run_nxt = 1'b0;
   end

   // a capture edge wins over a bus write in the same cycle
   always_comb
   begin
      a_val_nxt = a_val_r;
      if (cap_a)
         a_val_nxt = count_r;
      else if (wr & hit_a_dat)
         a_val_nxt = wmerge(a_val_r, wd, lanes);
   end

   always_comb
   begin
      b_val_nxt = b_val_r;
      if (cap_b)
         b_val_nxt = count_r;
      else if (wr & hit_b_dat)
         b_val_nxt = wmerge(b_val_r, wd, lanes);
   end

   // set wins over clear
   assign flag_nxt = flag_set | (flag_r & ~(flag_w1c | flag_rdc));

   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         ack_r <= 1'b0;
         dat_r <= RST_WORD;
      end
      else
      begin
         ack_r <= acc;
         dat_r <= rd ? rd_word : dat_r;
      end
   end

   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         run_r <= 1'b0;
         one_shot_r <= 1'b0;
         cbuf_r <= 1'b0;
         count_r <= RST_WORD;
      end
      else
      begin
         run_r <= run_nxt;
         one_shot_r <= wr_ctl ? wd[CTL_ONE_SHOT] : one_shot_r;
         cbuf_r <= wr_ctl ? wd[CTL_CBUF] : cbuf_r;
         count_r <= count_nxt;
      end
   end

   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         {a_edge_r, a_omode_r} <= {RST_FIELD2, RST_FIELD2};
         {b_edge_r, b_omode_r} <= {RST_FIELD2, RST_FIELD2};
         {a_inv_r, a_mode_r, b_inv_r, b_mode_r} <= 4'h0;
      end
      else
      begin
         if (wr_ccc_lo)
         begin
            a_edge_r <= wd[CC_A_EDGE +: 2];
            a_omode_r <= wd[CC_A_OMODE +: 2];
            a_inv_r <= wd[CC_A_INV];
            a_mode_r <= wd[CC_A_MODE];
         end
         if (wr_ccc_hi)
         begin
            b_edge_r <= wd[CC_B_EDGE +: 2];
            b_omode_r <= wd[CC_B_OMODE +: 2];
            b_inv_r <= wd[CC_B_INV];
            b_mode_r <= wd[CC_B_MODE];
         end
      end
   end

   // with buffering on, new compare values take effect only at the period end or while stopped
   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         a_val_r <= RST_WORD;
         b_val_r <= RST_WORD;
         a_act_r <= RST_WORD;
         b_act_r <= RST_WORD;
         flag_r <= RST_FLAGS;
         mask_r <= RST_FLAGS;
      end
      else
      begin
         a_val_r <= a_val_nxt;
         b_val_r <= b_val_nxt;
         if (!cbuf_r || !run_r || period_end)
         begin
            a_act_r <= a_val_r;
            b_act_r <= b_val_r;
         end
         flag_r <= flag_nxt;
         if (wr & hit_msk & lanes[0])
            mask_r <= wd[FLG_W-1:0];
      end
   end

   ptcc_edge_unit u_edge_a (
      .clk(CLK),
      .srst(SRST),
      .edge_sel(a_edge_r),
      .sig(CAP_A),
      .pulse(edge_a)
   );

   ptcc_edge_unit u_edge_b (
      .clk(CLK),
      .srst(SRST),
      .edge_sel(b_edge_r),
      .sig(CAP_B),
      .pulse(edge_b)
   );

   ptcc_output_unit u_out_a (
      .clk(CLK),
      .srst(SRST),
      .mode(a_omode_r),
      .inv(a_inv_r),
      .match_a(match_a),
      .match_b(match_b),
      .out(TIMER_OUTPUT_A)
   );

   ptcc_output_unit u_out_b (
      .clk(CLK),
      .srst(SRST),
      .mode(b_omode_r),
      .inv(b_inv_r),
      .match_a(match_a),
      .match_b(match_b),
      .out(TIMER_OUTPUT_B)
   );

   assign WB_ACK_O = ack_r;
   assign WB_DAT_O = {16'h0000, dat_r};
   assign IRQ = |(flag_r & mask_r);

   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);

   sequence s_req;
      WB_CYC_I && WB_STB_I && !ack_r;
   endsequence
   sequence s_ack_pulse;
      ack_r ##1 !ack_r;
   endsequence

   chk_bus_ack: assert property (s_req |=> s_ack_pulse)
      else $error("bus request not answered by a one-cycle ack");
   chk_run_reset: assert property ($fell(SRST) |-> !run_r && count_r == RST_WORD)
      else $error("counter not stopped and zero after reset");
   chk_count_hold: assert property (!run_r && !ctl_reset_wr |=> $stable(count_r))
      else $error("stopped counter moved");
   chk_count_step: assert property (tick && !period_end && !ctl_reset_wr |=> count_r == $past(count_r) + 16'h0001)
      else $error("running counter did not advance by one");
   chk_one_shot: assert property (period_end && one_shot_r && !wr_ctl |=> !run_r && count_r == RST_WORD)
      else $error("one-shot counter kept running");
   chk_repeat_run: assert property (period_end && !one_shot_r && !wr_ctl |=> run_r && count_r == RST_WORD)
      else $error("repeating counter did not restart");
   chk_ctl_reset: assert property (ctl_reset_wr |=> count_r == RST_WORD)
      else $error("counter reset write did not clear the count");
   chk_reset_bit_rd: assert property (rd && hit_ctl |=> !WB_DAT_O[CTL_RESET])
      else $error("counter reset bit read back as one");
   chk_capture_a: assert property (cap_a |=> a_val_r == $past(count_r))
      else $error("unit A did not capture the count");
   chk_capture_b: assert property (cap_b |=> b_val_r == $past(count_r))
      else $error("unit B did not capture the count");
   chk_match_flag: assert property (match_a |=> flag_r[FLG_MATCH_A] ##1 flag_r[FLG_MATCH_A] || $past(flag_w1c[FLG_MATCH_A] || flag_rdc[FLG_MATCH_A]))
      else $error("compare A flag not set or lost without a clear");
   chk_flag_w1c: assert property (flag_w1c[FLG_CAP_B] && !flag_set[FLG_CAP_B] |=> !flag_r[FLG_CAP_B])
      else $error("capture B flag not cleared by writing one");
endmodule

// File: test/ptcc_pins_model.sv
// ptcc_pins_model: far-side capture sources feeding the two capture pins
// assumes the bench raises requests in the CLK domain; pins stay synchronous to CLK
`timescale 1ns/1ps
module ptcc_pins_model
(
   input wire logic clk,
   input wire logic req_a,
   input wire logic req_b,
   output logic cap_a,
   output logic cap_b
);
   // registered like a synchronised pad, so each edge lands one cycle after its request
   initial
   begin
      cap_a = 1'b0;
      cap_b = 1'b0;
   end
   always @(posedge clk)
   begin
      cap_a <= req_a;
      cap_b <= req_b;
   end
endmodule

// File: test/ptcc_top_tb_top.sv
// ptcc_top_tb_top: self-checking bench for the timer channel against an integer model
// assumes the Wishbone slave acks every request and COUNT_TICK is a one-cycle pulse
`timescale 1ns/1ps
module ptcc_top_tb_top
   import ptcc_pkg::*;
;
   logic clk, srst, cyc, stb, we, tick, ra, rb, ca, cb, timer_output_a, timer_output_b, irq, ack;
   logic [3:0] sel, lsel;
   logic [17:0] adr;
   logic [31:0] dat, rdata, q;
   int fail_count, n_tests, seed, cnt, va, vb, pa, pb, run, osh, bf, am, bm, om, st, flg, v0;
   logic [15:0] ids [8] = '{IDX_CTL, IDX_CNT, IDX_CCC, IDX_A_DATA, IDX_B_DATA, IDX_MSK, IDX_FLG, 16'h5430};
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   ptcc_pins_model pins (.clk(clk), .req_a(ra), .req_b(rb), .cap_a(ca), .cap_b(cb));
   ptcc_top DUT (.CLK(clk), .SRST(srst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
      .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rdata), .WB_ACK_O(ack), .COUNT_TICK(tick),
      .CAP_A(ca), .CAP_B(cb), .TIMER_OUTPUT_A(timer_output_a), .TIMER_OUTPUT_B(timer_output_b), .IRQ(irq));
   task test_done;
   begin
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   end
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
   begin
      n_tests++;
      if (s !== e)
      begin
         fail_count++;
         $display("[ERR] t=%0t seen %h expected %h", $time, s, e);
      end
   end
   endtask
   // the request is held until ack is sampled; the wait is bounded so a dead slave cannot hang us
   task wb(input logic w, input logic [15:0] i, input int d);
      int k;
   begin
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {i, 2'b00};
      dat <= 32'(d) & 32'h0000ffff;
      sel <= lsel;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (ack !== 1'b1 && k < 50);
      q = rdata;
      if (k >= 50)
         fail_count++;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   end
   endtask
   task rdc(input logic [15:0] i, input int e);
   begin
      wb(1'b0, i, 0);
      chk(q, 32'(e));
   end
   endtask
   // one count tick, then the model steps exactly as the counter should on that edge
   task tk;
      int ma, mb;
   begin
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      // the active compare values follow the data registers unless buffered while running
      if (!bf || !run)
      begin
         pa = va;
         pb = vb;
      end
      ma = run && !am && cnt == pa;
      mb = run && !bm && cnt == pb;
      if (run && (mb || (bm && cnt == 65535)))
      begin
         cnt = 0;
         pa = va;
         pb = vb;
         if (osh)
            run = 0;
      end
      else if (run)
         cnt++;
      flg |= ma | (mb << 1);
      if (om == 1)
         st = ma ? 1 : (mb ? 0 : st);
      if (om == 2 && ma)
         st ^= 1;
      if (om == 3 && mb)
         st ^= 1;
   end
   endtask
   task pn(input logic v);
   begin
      @(posedge clk);
      ra <= v;
      rb <= v;
      repeat (4) @(posedge clk);
   end
   endtask
   task rst;
   begin
      srst <= 1'b1;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      cnt = 0;
      va = 0;
      vb = 0;
      pa = 0;
      pb = 0;
      run = 0;
      osh = 0;
      bf = 0;
      am = 0;
      bm = 0;
      om = 0;
      st = 0;
      flg = 0;
   end
   endtask
   initial
   begin
      repeat (20000) @(posedge clk);
      fail_count++;
      test_done;
   end
   initial
   begin
      seed = 17220;
      fail_count = 0;
      n_tests = 0;
      {cyc, stb, we, tick, ra, rb} = 6'h00;
      adr = '0;
      dat = '0;
      sel = 4'h0;
      lsel = 4'h3;
      rst;
      chk(timer_output_a, 0);
      chk(timer_output_b, 0);
      chk(irq, 0);
      foreach (ids[j])
         rdc(ids[j], 0);
      va = $random(seed) & 16'hffff;
      vb = $random(seed) & 16'hffff;
      wb(1'b1, IDX_A_DATA, va);
      wb(1'b1, IDX_B_DATA, vb);
      wb(1'b1, IDX_CNT, 16'h1234);
      rdc(IDX_A_DATA, va);
      rdc(IDX_B_DATA, vb);
      rdc(IDX_CNT, 0);
      va = 2;
      vb = 5;
      wb(1'b1, IDX_A_DATA, va);
      wb(1'b1, IDX_B_DATA, vb);
      wb(1'b1, IDX_MSK, 1);
      wb(1'b1, IDX_CTL, 1);
      run = 1;
      repeat (8) tk;
      rdc(IDX_CNT, cnt);
      chk(irq, 1);
      wb(1'b1, IDX_FLG, 16'h3f);
      flg = 0;
      chk(irq, 0);
      wb(1'b1, IDX_CTL, 0);
      run = 0;
      tk;
      rdc(IDX_CNT, cnt);
      wb(1'b1, IDX_CTL, 3);
      cnt = 0;
      run = 1;
      rdc(IDX_CTL, 1);
      rdc(IDX_CNT, 0);
      wb(1'b1, IDX_CTL, 5);
      osh = 1;
      repeat (7) tk;
      rdc(IDX_CNT, cnt);
      rdc(IDX_CTL, 4 + run);
      rdc(IDX_FLG, flg);
      flg = 0;
      wb(1'b1, IDX_CTL, 1);
      run = 1;
      osh = 0;
      am = 1;
      bm = 1;
      for (int e = 0; e < 4; e++)
      begin
         wb(1'b1, IDX_CCC, 1 | (e << 6) | (1 << 8) | (e << 14));
         wb(1'b0, IDX_FLG, 0);
         v0 = cnt;
         pn(1'b1);
         tk;
         pn(1'b0);
         va = (e == 1) ? v0 : ((e > 1) ? cnt : va);
         vb = (e == 1) ? v0 : ((e > 1) ? cnt : vb);
         rdc(IDX_FLG, e == 0 ? 0 : (e == 3 ? 16'h3c : 16'h0c));
         rdc(IDX_A_DATA, va);
         rdc(IDX_B_DATA, vb);
      end
      // a fresh reset per output mode, so no leftover output state leaks between modes
      for (int m = 0; m < 4; m++)
      begin
         rst;
         om = m;
         va = 2;
         vb = 5;
         wb(1'b1, IDX_A_DATA, va);
         wb(1'b1, IDX_B_DATA, vb);
         wb(1'b1, IDX_CCC, (m << 4) | (1 << 9) | (m << 12));
         wb(1'b1, IDX_CTL, 1);
         run = 1;
         repeat (13)
         begin
            tk;
            repeat (3) @(posedge clk);
            chk(timer_output_a, 32'(m ? st : 0));
            chk(timer_output_b, 32'(m ? !st : 1));
         end
      end
      // compare buffering: a new value written while running waits for the period end
      rst;
      va = 2;
      vb = 5;
      wb(1'b1, IDX_A_DATA, va);
      wb(1'b1, IDX_B_DATA, vb);
      wb(1'b1, IDX_CTL, 9);
      pa = va;
      pb = vb;
      bf = 1;
      run = 1;
      rdc(IDX_CTL, 9);
      repeat (3) tk;
      // only the low byte lane is enabled, so the high byte keeps its old zero
      va = 4;
      lsel = 4'h1;
      wb(1'b1, IDX_A_DATA, 16'hab04);
      lsel = 4'h3;
      rdc(IDX_A_DATA, va);
      wb(1'b0, IDX_FLG, 0);
      flg = 0;
      repeat (2) tk;
      rdc(IDX_FLG, flg);
      flg = 0;
      repeat (7) tk;
      rdc(IDX_FLG, flg);
      rdc(IDX_CNT, cnt);
      test_done;
   end
endmodule
